// ---- core/sac_ctrl.sv ----
// Purpose: control unit of an 8-bit successive-approximation converter
// Assumes: comparator answers asynchronously whether input >= dac_code
// Notes: registers reached over an Avalon-MM slave with waitrequest
//
// Contract
// R01: channel change waits until conversion completes
// R02: codes 00..11 route inputs 0..3
// R03: free-run restart keeps the old channel
// R04: software picks channel before starting
// R05: software avoids channel writes in free run
// R06: halted sleep starts a single conversion
// R07: sleep-started conversion finishes and raises request
// R08: other sleep modes never disable converter
// R09: result is input times 256 over reference
// R10: result readable once complete flag set
// R11: enable bit on; clearing it aborts
// R12: start bit launches a conversion
// R13: first conversion 25 cycles, later 13
// R14: start reads busy; writing zero ignored
// R15: auto trigger starts on selected rising edge
// R16: outside pins stay quiet during conversion
// R17: complete flag set on end, cleared two ways
// R18: divider codes give 2 to 128
// R19: trigger select picks free run or source
// R20: prescaler runs only while enabled
// R21: abort leaves result and flag untouched
// R22: result and flag change together
//
// The Avalon-MM interface to the registers is this design's own decision.

`timescale 1ns/100ps

module sac_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [6:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comparator_async,
  input wire logic [6:0] trigger_sources,
  input wire logic cpu_sleep_halted,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [3:0] input_select,
  output logic [7:0] dac_code
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic en_reg, en_next, ate_reg, ate_next, ie_reg, ie_next;
  logic flag_reg, flag_next, irq_reg, irq_next;
  logic [2:0] div_reg, div_next, tsel_reg, tsel_next;
  logic [1:0] chan_reg, chan_next, act_reg, act_next;
  logic [7:0] result_reg, result_next, work_reg, work_next;
  logic [7:0] mask_reg, mask_next;
  logic [4:0] cyc_reg, cyc_next, last_cyc, sh_cyc;
  logic first_reg, first_next, trig_prev_reg, sleep_prev_reg;
  logic [3:0] sel_reg;
  sac_pkg::sac_state_e state_reg, state_next;
  logic acc, wr, sel_a, sel_b, sel_chan, sel_res;
  logic [7:0] wd, rd_byte;
  logic tick, cmp, trig_sig, trig_start, sleep_start, sw_start;
  logic done, restart, en_rise, flag_clr, presc_clear;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  sac_sync u_cmp_sync (
    .clk(clk),
    .resetn(resetn),
    .d(comparator_async),
    .q(cmp)
  );

  // trigger restart also clears the prescaler for a fixed start delay
  assign presc_clear = !en_reg || trig_start;

  sac_prescaler u_presc (
    .clk(clk),
    .resetn(resetn),
    .clear(presc_clear),
    .div_code(div_reg),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // decode and write strobes; access completes when waitrequest is low
  assign acc = (avs_read || avs_write) && !wait_reg;
  assign wr = acc && avs_write && avs_byteenable[0];
  assign wd = avs_writedata[7:0];
  assign sel_a = avs_address == sac_pkg::ADDR_CTRL_A;
  assign sel_b = avs_address == sac_pkg::ADDR_CTRL_B;
  assign sel_chan = avs_address == sac_pkg::ADDR_CHAN;
  assign sel_res = avs_address == sac_pkg::ADDR_RESULT;

  // read view; unmapped addresses read zero
  always_comb begin
    rd_byte = sac_pkg::RESET_BYTE;
    if (sel_a) begin
      rd_byte[sac_pkg::BIT_EN] = en_reg;
      rd_byte[sac_pkg::BIT_START] = state_reg != sac_pkg::ST_IDLE; // R14
      rd_byte[sac_pkg::BIT_ATE] = ate_reg;
      rd_byte[sac_pkg::BIT_FLAG] = flag_reg;
      rd_byte[sac_pkg::BIT_IE] = ie_reg;
      rd_byte[sac_pkg::DIV_MSB:0] = div_reg;
    end else if (sel_b) begin
      rd_byte[sac_pkg::TSEL_MSB:0] = tsel_reg;
    end else if (sel_chan) begin
      rd_byte[sac_pkg::CHAN_MSB:0] = chan_reg;
    end else if (sel_res) begin
      rd_byte = result_reg; // R10
    end
  end

  // one wait cycle per request keeps read data a flop output
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    en_next = en_reg;
    ate_next = ate_reg;
    ie_next = ie_reg;
    div_next = div_reg;
    tsel_next = tsel_reg;
    chan_next = chan_reg;
    if (wr && sel_a) begin
      en_next = wd[sac_pkg::BIT_EN]; // R11
      ate_next = wd[sac_pkg::BIT_ATE];
      ie_next = wd[sac_pkg::BIT_IE];
      div_next = wd[sac_pkg::DIV_MSB:0];
    end
    if (wr && sel_b) begin
      tsel_next = wd[sac_pkg::TSEL_MSB:0];
    end
    if (wr && sel_chan) begin
      chan_next = wd[sac_pkg::CHAN_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_reg <= 1'b0;
      ate_reg <= 1'b0;
      ie_reg <= 1'b0;
      div_reg <= 3'h0;
      tsel_reg <= 3'h0;
      chan_reg <= 2'h0;
    end else begin
      en_reg <= en_next;
      ate_reg <= ate_next;
      ie_reg <= ie_next;
      div_reg <= div_next;
      tsel_reg <= tsel_next;
      chan_reg <= chan_next;
    end
  end

  // ---------------------------------------------------------------
  // start sources
  // ---------------------------------------------------------------
  // code 000 is free running and never makes an edge itself
  assign trig_sig = (tsel_reg == sac_pkg::TSEL_FREE) ? 1'b0 :
                    trigger_sources[3'(tsel_reg - 3'h1)]; // R19
  // edges while busy are dropped, not queued
  assign trig_start = ate_reg && trig_sig && !trig_prev_reg && en_reg &&
                      state_reg == sac_pkg::ST_IDLE; // R15
  // only the halted idle or noise-reduction sleep reaches this input
  assign sleep_start = cpu_sleep_halted && !sleep_prev_reg && en_reg &&
                       !ate_reg && ie_reg && state_reg == sac_pkg::ST_IDLE; // R06 R08
  assign sw_start = wr && sel_a && wd[sac_pkg::BIT_START] && en_next; // R12 R14
  assign en_rise = en_next && !en_reg;
  assign last_cyc = first_reg ? sac_pkg::LEN_FIRST - 5'h01 :
                    sac_pkg::LEN_NORMAL - 5'h01; // R13
  assign sh_cyc = first_reg ? sac_pkg::SH_FIRST : sac_pkg::SH_NORMAL;
  assign done = state_reg == sac_pkg::ST_CONV && tick && cyc_reg == last_cyc;
  // free running restarts at once, whatever the flag holds
  assign restart = done && ate_reg && tsel_reg == sac_pkg::TSEL_FREE && en_next;
  assign flag_clr = irq_ack || (wr && sel_a && wd[sac_pkg::BIT_FLAG]);

  // ---------------------------------------------------------------
  // conversion engine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    work_next = work_reg;
    mask_next = mask_reg;
    result_next = result_reg;
    act_next = act_reg;
    case (state_reg)
      sac_pkg::ST_IDLE: begin
        if (sw_start || trig_start || sleep_start) begin
          state_next = sac_pkg::ST_WAIT;
        end
      end
      sac_pkg::ST_WAIT: begin
        // conversion begins on the next converter clock edge
        if (tick) begin
          state_next = sac_pkg::ST_CONV;
          cyc_next = 5'h00;
          mask_next = 8'h00;
        end
      end
      sac_pkg::ST_CONV: begin
        if (tick) begin
          cyc_next = cyc_reg + 5'h01;
          if (cyc_reg == sh_cyc) begin
            work_next = sac_pkg::SAR_MSB;
            mask_next = sac_pkg::SAR_MSB;
          end else if (mask_reg != 8'h00) begin
            // keep the trial bit only if input >= trial level
            work_next = (cmp ? work_reg : (work_reg & ~mask_reg)) |
                        (mask_reg >> 1); // R09
            mask_next = mask_reg >> 1;
          end
          if (done) begin
            result_next = work_next; // R22
            cyc_next = 5'h00;
            mask_next = 8'h00;
            state_next = restart ? sac_pkg::ST_CONV : sac_pkg::ST_IDLE; // R14
          end
        end
      end
      default: begin
        state_next = sac_pkg::ST_IDLE;
      end
    endcase
    // selection follows the register except while a conversion holds it
    if (state_reg != sac_pkg::ST_CONV || (tick && cyc_reg == last_cyc)) begin
      act_next = chan_reg; // R01 R03
    end
    if (!en_next) begin
      state_next = sac_pkg::ST_IDLE; // R11 R21
      result_next = result_reg;
    end
  end

  // flag set by completion wins over any clear in the same cycle
  always_comb begin
    first_next = en_rise || (first_reg && !done); // R13
    flag_next = flag_reg;
    if (flag_clr) begin
      flag_next = 1'b0; // R17
    end
    if (done && en_next) begin
      flag_next = 1'b1; // R17 R07 R22
    end
    irq_next = flag_next && ie_next;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= sac_pkg::ST_IDLE;
      cyc_reg <= 5'h00;
      work_reg <= 8'h00;
      mask_reg <= 8'h00;
      result_reg <= sac_pkg::RESET_BYTE;
      act_reg <= 2'h0;
      first_reg <= 1'b0;
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      sleep_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      work_reg <= work_next;
      mask_reg <= mask_next;
      result_reg <= result_next;
      act_reg <= act_next;
      first_reg <= first_next;
      flag_reg <= flag_next;
      irq_reg <= irq_next;
      trig_prev_reg <= trig_sig;
      sleep_prev_reg <= cpu_sleep_halted;
    end
  end

  // ---------------------------------------------------------------
  // input routing, one enable per analog input
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_route
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sel_reg[gi] <= (gi == 0);
        end else begin
          sel_reg[gi] <= act_next == 2'(gi); // R02
        end
      end
    end
  endgenerate

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign irq_req = irq_reg;
  assign input_select = sel_reg;
  assign dac_code = work_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  result_with_flag_a: assert property (done && en_next |=>
    flag_reg && result_reg == $past(work_next)) // R22
    else $error("result and complete flag did not update together");
  abort_clean_a: assert property (en_reg && !en_next |=>
    state_reg == sac_pkg::ST_IDLE && $stable(result_reg)) // R21
    else $error("disable did not abort cleanly");
  chan_locked_a: assert property (state_reg == sac_pkg::ST_CONV &&
    !(tick && cyc_reg == last_cyc) |=> $stable(act_reg)) // R01
    else $error("channel changed during a conversion");
  route_onehot_a: assert property (input_select == (4'h1 << act_reg)) // R02
    else $error("input routing does not match channel code");
  conv_length_a: assert property (done |->
    cyc_reg == (first_reg ? 5'h18 : 5'h0C)) // R13
    else $error("conversion length wrong");
  zero_start_a: assert property (wr && sel_a && !wd[sac_pkg::BIT_START] &&
    state_reg == sac_pkg::ST_IDLE |=> state_reg == sac_pkg::ST_IDLE) // R14
    else $error("writing zero to start had an effect");
  presc_held_a: assert property (!en_reg [*2] |-> !tick) // R20
    else $error("prescaler ticked while disabled");
  trig_start_a: assert property (trig_start |=>
    state_reg == sac_pkg::ST_WAIT ##1 !tick) // R15
    else $error("trigger edge did not start a conversion");
  sleep_start_a: assert property (sleep_start |=>
    state_reg == sac_pkg::ST_WAIT) // R06
    else $error("halted sleep did not start a conversion");
  flag_set_wins_a: assert property (done && en_next && flag_clr |=> flag_reg) // R17
    else $error("clear beat a completion");

  first_done_c: cover property (done && first_reg);
  free_restart_c: cover property (restart ##1 state_reg == sac_pkg::ST_CONV);
  abort_c: cover property (state_reg == sac_pkg::ST_CONV && !en_next);
  sleep_conv_c: cover property (sleep_start ##[1:400] done);

endmodule

// ---- core/sac_pkg.sv ----
// Purpose: shared constants and types of the converter control unit
// Assumes: registers sit one per 32-bit word, byte address is four times the index
// Notes: conversion lengths and sample points count converter clock cycles

package sac_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_RESULT = 8'h19;
  localparam logic [7:0] IDX_CHAN = 8'h1B;
  localparam logic [7:0] IDX_CTRL_B = 8'h1C;
  localparam logic [7:0] IDX_CTRL_A = 8'h1D;
  localparam logic [6:0] ADDR_RESULT = 7'(IDX_RESULT * 4);
  localparam logic [6:0] ADDR_CHAN = 7'(IDX_CHAN * 4);
  localparam logic [6:0] ADDR_CTRL_B = 7'(IDX_CTRL_B * 4);
  localparam logic [6:0] ADDR_CTRL_A = 7'(IDX_CTRL_A * 4);
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // field positions of control and status register a, register b and the channel register
  // ---------------------------------------------------------------
  localparam int BIT_EN = 7;
  localparam int BIT_START = 6;
  localparam int BIT_ATE = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_IE = 3;
  localparam int DIV_MSB = 2;
  localparam int CHAN_MSB = 1;
  localparam int TSEL_MSB = 2;
  localparam logic [2:0] TSEL_FREE = 3'h0;

  // ---------------------------------------------------------------
  // conversion timing in converter clock cycles
  // ---------------------------------------------------------------
  localparam logic [4:0] LEN_FIRST = 5'h19;
  localparam logic [4:0] LEN_NORMAL = 5'h0D;
  localparam logic [4:0] SH_FIRST = 5'h10;
  localparam logic [4:0] SH_NORMAL = 5'h03;
  localparam logic [7:0] SAR_MSB = 8'h80;

  // prescaler terminal counts: divide by 2,2,4,8,16,32,64,128
  localparam logic [6:0] PS_LIM [0:7] = '{7'h01, 7'h01, 7'h03, 7'h07,
                                          7'h0F, 7'h1F, 7'h3F, 7'h7F};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } sac_state_e;

endpackage

// ---- core/sac_prescaler.sv ----
// Purpose: converter clock prescaler giving one tick per converter cycle
// Assumes: clear is held while the converter is off or a trigger restarts it
// Notes: tick is a one-cycle pulse from a flop

`timescale 1ns/100ps

module sac_prescaler (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic [2:0] div_code,
  output logic tick
);

  logic [6:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  // counter runs only while not cleared; terminal count picks the divide
  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 7'h01;
    if (clear) begin
      cnt_next = 7'h00; // R20
    end else if (cnt_reg >= sac_pkg::PS_LIM[div_code]) begin
      cnt_next = 7'h00; // R18
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// ---- core/sac_sync.sv ----
// Purpose: three-stage synchroniser for an asynchronous level
// Assumes: input may change at any time relative to clk
// Notes: output follows only when the second and third stages agree

`timescale 1ns/100ps

module sac_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic d,
  output logic q
);

  logic s1_reg, s2_reg, s3_reg, q_reg;
  logic q_next;

  // a glitch that reaches only one stage never moves the output
  always_comb begin
    q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// ---- dv/sac_analog_model.sv ----
// Purpose: four analog input pins and the comparator of the converter
// Assumes: each level is a steady code of the reference, 0x00 is ground
// Notes: comparator stays low while no input is routed
`timescale 1ns/100ps

module sac_analog_model (
  input wire logic [3:0] input_select,
  input wire logic [7:0] dac_code,
  input wire logic [7:0] level_0,
  input wire logic [7:0] level_1,
  input wire logic [7:0] level_2,
  input wire logic [7:0] level_3,
  output logic comparator_async
);
  logic [7:0] vin;

  // one-hot route, pin i feeds input i
  always_comb begin
    case (input_select)
      4'h1: vin = level_0;
      4'h2: vin = level_1;
      4'h4: vin = level_2;
      4'h8: vin = level_3;
      default: vin = 8'h00;
    endcase
  end

  // ideal comparator, so a clean search lands on the level itself
  assign comparator_async = (input_select != 4'h0) && (vin >= dac_code);
endmodule

// ---- dv/sac_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the converter control unit
// Assumes: divider code 011 wherever a result is judged
// Notes: waits poll the complete flag; every run ends in stop_test
`timescale 1ns/100ps

module sac_ctrl_tb_top;
  // ----------
  // signals
  // ----------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic comparator_async;
  logic [6:0] trigger_sources = 7'h00;
  logic cpu_sleep_halted = 1'b0;
  logic irq_ack = 1'b0;
  logic irq_req;
  logic [3:0] input_select;
  logic [7:0] dac_code;
  // levels never move during a conversion: a noisy pin would spoil results
  logic [7:0] lvl [0:3] = '{8'h3C, 8'hA5, 8'hFF, 8'h00};
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0 = 0;
  int el = 0;
  logic [31:0] rd;

  sac_ctrl u_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_byteenable(4'hF), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comparator_async(comparator_async),
    .trigger_sources(trigger_sources), .cpu_sleep_halted(cpu_sleep_halted),
    .irq_ack(irq_ack), .irq_req(irq_req), .input_select(input_select),
    .dac_code(dac_code));

  sac_analog_model u_afe (.input_select(input_select), .dac_code(dac_code),
    .level_0(lvl[0]), .level_1(lvl[1]), .level_2(lvl[2]), .level_3(lvl[3]),
    .comparator_async(comparator_async));

  // 50 MHz clock and a cycle count for length checks
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ----------
  // shared tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  // one bus cycle, held until waitrequest is seen low; no cycle count is assumed
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    // a slave that never answers is left to the watchdog
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdr(input logic [6:0] a);
    bus(1'b0, a, 8'h00);
  endtask

  task automatic go(input logic [7:0] c);
    wr(sac_pkg::ADDR_CTRL_A, c);
    t0 = cyc;
  endtask

  // poll of the flag, a hang ends in the watchdog; el is cycles since the last go
  task automatic wait_flag();
    do begin
      rdr(sac_pkg::ADDR_CTRL_A);
    end while (rd[sac_pkg::BIT_FLAG] !== 1'b1);
    el = cyc - t0;
  endtask

  task automatic ack();
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
  endtask

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_reset();
    rdr(sac_pkg::ADDR_CTRL_A);
    chk("ctrl_a reset", rd, 32'h0);
    rdr(sac_pkg::ADDR_CHAN);
    chk("channel reset", rd, 32'h0);
    rdr(sac_pkg::ADDR_RESULT);
    chk("result reset", rd, 32'h0);
    rdr(7'h00);
    chk("unmapped read", rd, 32'h0);
    chk("route reset", 32'(input_select), 32'h1);
  endtask

  task automatic t_chan();
    for (int ch = 0; ch < 4; ch++) begin
      wr(sac_pkg::ADDR_CHAN, 8'(ch));
      go(8'hD3);
      wait_flag();
      chk("start clear", 32'(rd[sac_pkg::BIT_START]), 32'h0);
      chk("route", 32'(input_select), 32'(1 << ch));
      rdr(sac_pkg::ADDR_RESULT);
      chk("result", rd, 32'(lvl[ch]));
      // the last trial word of a clean search is the level itself
      chk("trial word", 32'(dac_code), 32'(lvl[ch]));
    end
  endtask

  task automatic t_switch();
    wr(sac_pkg::ADDR_CHAN, 8'h01);
    go(8'hD3);
    // channel may change one converter clock after start
    repeat (16) @(posedge clk);
    wr(sac_pkg::ADDR_CHAN, 8'h02);
    wr(sac_pkg::ADDR_CTRL_A, 8'h83);
    rdr(sac_pkg::ADDR_CTRL_A);
    chk("zero start ignored", 32'(rd[sac_pkg::BIT_START]), 32'h1);
    chk("route held", 32'(input_select), 32'h2);
    wait_flag();
    rdr(sac_pkg::ADDR_RESULT);
    chk("old channel result", rd, 32'(lvl[1]));
    chk("route updated", 32'(input_select), 32'h4);
  endtask

  task automatic t_abort();
    go(8'hD3);
    repeat (16) @(posedge clk);
    wr(sac_pkg::ADDR_CTRL_A, 8'h03);
    // longer than any conversion at this divider
    repeat (240) @(posedge clk);
    rdr(sac_pkg::ADDR_CTRL_A);
    chk("abort status", rd, 32'h03);
    rdr(sac_pkg::ADDR_RESULT);
    chk("abort result", rd, 32'(lvl[1]));
  endtask

  task automatic t_irq();
    go(8'hDB);
    wait_flag();
    repeat (2) @(posedge clk);
    chk("irq raised", 32'(irq_req), 32'h1);
    ack();
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'(irq_req), 32'h0);
    rdr(sac_pkg::ADDR_CTRL_A);
    chk("flag cleared", 32'(rd[sac_pkg::BIT_FLAG]), 32'h0);
  endtask

  task automatic t_sleep();
    int n;
    wr(sac_pkg::ADDR_CTRL_A, 8'h9B);
    cpu_sleep_halted <= 1'b1;
    repeat (20) @(posedge clk);
    // an early wake by some other source
    cpu_sleep_halted <= 1'b0;
    rdr(sac_pkg::ADDR_CTRL_A);
    chk("sleep start", 32'(rd[sac_pkg::BIT_START]), 32'h1);
    // vector ack held over the end: completion must still win the flag
    irq_ack <= 1'b1;
    for (n = 0; n < 400 && irq_req !== 1'b1; n++) @(posedge clk);
    irq_ack <= 1'b0;
    chk("sleep irq", 32'(irq_req), 32'h1);
    rdr(sac_pkg::ADDR_CTRL_A);
    chk("ack after set", 32'(rd[sac_pkg::BIT_FLAG]), 32'h0);
    rdr(sac_pkg::ADDR_RESULT);
    chk("sleep result", rd, 32'(lvl[2]));
    ack();
  endtask

  task automatic t_trig();
    for (int k = 1; k < 8; k++) begin
      wr(sac_pkg::ADDR_CTRL_B, 8'(k));
      go(8'hB3);
      trigger_sources <= 7'(1 << (k % 7));
      repeat (40) @(posedge clk);
      rdr(sac_pkg::ADDR_CTRL_A);
      chk("other source", 32'(rd[sac_pkg::BIT_START]), 32'h0);
      trigger_sources <= 7'(1 << (k - 1));
      wait_flag();
      trigger_sources <= 7'h00;
      rdr(sac_pkg::ADDR_RESULT);
      chk("trigger result", rd, 32'(lvl[2]));
    end
  endtask

  task automatic t_free();
    wr(sac_pkg::ADDR_CTRL_B, 8'h00);
    wr(sac_pkg::ADDR_CHAN, 8'h00);
    go(8'hF3);
    wait_flag();
    chk("free restart", 32'(rd[sac_pkg::BIT_START]), 32'h1);
    // the only channel write in free run, right after a completion
    wr(sac_pkg::ADDR_CHAN, 8'h03);
    go(8'hB3);
    wait_flag();
    rdr(sac_pkg::ADDR_RESULT);
    chk("free old channel", rd, 32'(lvl[0]));
    go(8'hB3);
    wait_flag();
    rdr(sac_pkg::ADDR_RESULT);
    chk("free new channel", rd, 32'(lvl[3]));
    wr(sac_pkg::ADDR_CTRL_A, 8'h00);
  endtask

  // first and normal length at every divider code
  task automatic t_div();
    int d;
    for (int c = 0; c < 8; c++) begin
      d = (c < 2) ? 2 : (1 << c);
      wr(sac_pkg::ADDR_CTRL_A, 8'h00);
      go(8'hD0 | 8'(c));
      wait_flag();
      chk("first length", 32'(el >= 24 * d && el <= 26 * d + 8), 32'h1);
      go(8'hD0 | 8'(c));
      wait_flag();
      chk("normal length", 32'(el >= 12 * d && el <= 14 * d + 8), 32'h1);
    end
  endtask

  // main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_chan();
    t_switch();
    t_abort();
    t_irq();
    t_sleep();
    t_trig();
    t_free();
    t_div();
    stop_test();
  end

  // watchdog, well beyond the expected run of some 15000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule
